// [hw/tnvm_top.sv]
// ============================================================
// Purpose: two-wire slave byte engine with a 2,048 byte array
// Assumes: SCL and SDA_IN are raw pins, WP is a static strap
// Notes: a decision for the line is made one slot ahead
// ============================================================
module tnvm_top #(
   parameter logic [3:0] DEV_TYPE = tnvm_pkg::DEV_TYPE_DFLT, // value is arbitrary
   parameter int FIFO_DEPTH = tnvm_pkg::FIFO_DEPTH
) (
   // system clock and power-on reset
   input wire logic SYS_CLK,
   input wire logic RST_B,
   // two-wire bus
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   // write protect strap
   input wire logic WP
);
   import tnvm_pkg::*;

   // ============================================================
   // state
   typedef struct packed {
      logic [1:0] scl_y;
      logic scl_p;
      logic [1:0] sda_y;
      logic sda_p;
      logic [1:0] tog_y;
      logic tog_p;
      logic [1:0] wp_y;
      tnvm_phase_t phase;
      logic [3:0] cnt;
      logic [BYTE_W-1:0] sh;
      logic [BYTE_W-1:0] tx;
      logic [ADDR_W-1:0] addr;
      logic ack;
      logic rw_rd;
      logic drv;
      logic gate;
   } tnvm_state_t;

   localparam tnvm_state_t ST_RST = '{
      scl_y: 2'h3, scl_p: 1'b1, sda_y: 2'h3, sda_p: 1'b1,
      tog_y: 2'h0, tog_p: 1'b0, wp_y: 2'h0, phase: P_IDLE,
      cnt: CNT_RST, sh: BYTE_RST, tx: BYTE_RST, addr: ADDR_RST,
      ack: 1'b0, rw_rd: 1'b0, drv: 1'b0, gate: 1'b0};

   tnvm_state_t q, d;
   logic [BYTE_W-1:0] mem_q [0:MEM_BYTES-1];
   logic bit_v, bit_tog;
   logic scl_s, sda_s, wp_s;
   logic rise_ev, fall_ev, start_ev, stop_ev;
   logic [BYTE_W-1:0] sh_new;
   logic f_push, f_in_ready, f_out_valid, f_out_ready;
   logic [FIFO_W-1:0] f_in_data, f_out_data;
   logic fetch;
   logic [ADDR_W-1:0] fetch_addr;
   logic ack_ok;

   // ============================================================
   // checks
   if (FIFO_DEPTH < 2) begin : g_bad_fifo
      $error("write queue needs at least two entries");
   end

   // ============================================================
   // helpers
   // type code from the first seven bits of the slave address
   function automatic logic [3:0] sa_type(input logic [6:0] seven);
      return seven[SA_TYPE_LSB-1 +: 4];
   endfunction

   // next address, wraps at the top of the array
   function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
      return a + ADDR_ONE;
   endfunction

   // bit for the slot that starts at the next falling edge
   function automatic logic tx_bit(input logic [BYTE_W-1:0] b, input logic [3:0] c);
      logic [3:0] i;
      i = CNT_LAST_TX - c;
      return b[i[2:0]];
   endfunction

   // ============================================================
   // serial clock side
   tnvm_link u_link (
      .scl(SCL),
      .rst_b(RST_B),
      .sda_in(SDA_IN),
      .drv_req(q.drv),
      .drv_gate(q.gate),
      .bit_q(bit_v),
      .bit_tog_q(bit_tog),
      .sda_oe_q(SDA_OE)
   );

   // open drain: the pin only ever pulls low
   assign SDA_OUT = 1'b0; // [RULE11]

   // ============================================================
   // bus events from synchronised levels
   assign scl_s = q.scl_y[1];
   assign sda_s = q.sda_y[1];
   assign wp_s = q.wp_y[1];
   assign rise_ev = q.tog_y[1] ^ q.tog_p;
   assign fall_ev = q.scl_p && !scl_s;
   assign start_ev = scl_s && q.scl_p && q.sda_p && !sda_s;
   assign stop_ev = scl_s && q.scl_p && !q.sda_p && sda_s;
   assign sh_new = {q.sh[BYTE_W-2:0], bit_v};

   // write queue into the array
   assign f_in_data = {q.addr, sh_new};
   assign f_out_ready = !fetch; // array port busy while a read fetch runs

   tnvm_fifo #(
      .W(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .in_valid(f_push),
      .in_ready(f_in_ready),
      .in_data(f_in_data),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out_data)
   );

   // ============================================================
   // byte engine
   always_comb begin
      d = q;
      f_push = 1'b0;
      fetch = 1'b0;
      fetch_addr = q.addr;
      ack_ok = 1'b0;
      // two-flop synchronisers and edge history
      d.scl_y = {q.scl_y[0], SCL};
      d.sda_y = {q.sda_y[0], SDA_IN};
      d.tog_y = {q.tog_y[0], bit_tog};
      d.wp_y = {q.wp_y[0], WP};
      d.scl_p = scl_s;
      d.sda_p = sda_s;
      d.tog_p = q.tog_y[1];
      if (start_ev) begin
         // drop the operation, keep the address latch, and wait for a slave address
         d.phase = P_DEV; // [RULE13]
         d.cnt = CNT_RST;
         d.ack = 1'b0;
         d.drv = 1'b0;
         d.gate = 1'b0;
      end else if (stop_ev) begin
         d.phase = P_IDLE;
         d.drv = 1'b0;
         d.gate = 1'b0;
      end else if (q.phase != P_IDLE && q.phase != P_DROP) begin
         // rising edge: a data bit or the end of the acknowledge slot
         if (rise_ev) begin
            if (q.cnt == CNT_ACK) begin
               d.cnt = CNT_RST;
               unique case (q.phase)
                  P_DEV: d.phase = !q.ack ? P_DROP : (q.rw_rd ? P_RD : P_WORD);
                  P_WORD: d.phase = P_WR;
                  P_WR: d.phase = q.ack ? P_WR : P_DROP;
                  P_RD: d.phase = bit_v ? P_DROP : P_RD; // master no-ack ends the read
                  default: d.phase = P_IDLE;
               endcase
               if (d.phase == P_DROP) begin
                  d.drv = 1'b0;
                  d.gate = 1'b0;
               end
            end else begin
               d.sh = sh_new; // [RULE3]
               d.cnt = q.cnt + 4'h1;
               if (q.cnt == CNT_LAST_DATA) begin
                  unique case (q.phase)
                     P_DEV: begin
                        // page select and direction from the slave address
                        d.addr[ADDR_W-1 -: PAGE_W] = sh_new[SA_PAGE_LSB +: PAGE_W]; // [RULE14] [RULE7]
                        d.rw_rd = sh_new[SA_RW_BIT]; // [RULE14]
                        if (q.ack && sh_new[SA_RW_BIT]) begin
                           fetch = 1'b1;
                           fetch_addr = {sh_new[SA_PAGE_LSB +: PAGE_W], q.addr[WORD_W-1:0]};
                        end
                     end
                     P_WORD: begin
                        // page stays on top, word byte below
                        d.addr = {q.addr[ADDR_W-1 -: PAGE_W], sh_new}; // [RULE6] [RULE8]
                     end
                     P_WR: begin
                        // refused bytes leave the latch alone
                        if (q.ack) begin
                           f_push = 1'b1; // [RULE9]
                           d.addr = addr_inc(q.addr); // [RULE15] [RULE16]
                        end
                     end
                     P_RD: begin
                        // byte sent: step and fetch the next one
                        d.addr = addr_inc(q.addr); // [RULE15]
                        fetch = 1'b1;
                        fetch_addr = addr_inc(q.addr);
                     end
                     default: d.addr = q.addr;
                  endcase
               end
            end
         end
         // falling edge: choose what the line shows after the next fall
         if (fall_ev) begin
            d.gate = 1'b0;
            d.drv = 1'b0;
            if (q.cnt == CNT_LAST_DATA) begin
               unique case (q.phase)
                  P_DEV: ack_ok = sa_type(q.sh[6:0]) == DEV_TYPE; // [RULE17]
                  P_WORD: ack_ok = 1'b1;
                  P_WR: ack_ok = !(wp_s && q.addr[ADDR_W-1]) && f_in_ready; // [RULE4] [RULE5] [RULE16]
                  P_RD: ack_ok = 1'b0; // master owns this acknowledge
                  default: ack_ok = 1'b0;
               endcase
               d.ack = ack_ok;
               d.drv = ack_ok;
            end else if (q.cnt == CNT_ACK) begin
               if (q.phase == P_RD || (q.phase == P_DEV && q.ack && q.rw_rd)) begin
                  d.drv = !q.tx[BYTE_W-1]; // [RULE2]
                  d.gate = q.phase == P_RD;
               end
            end else if (q.phase == P_RD && q.cnt <= CNT_LAST_TX) begin
               d.drv = !tx_bit(q.tx, q.cnt); // [RULE2]
            end
         end
      end
      if (fetch) d.tx = mem_q[fetch_addr];
   end

   // ============================================================
   // state register, power-on reset only
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) q <= ST_RST; // [RULE12]
      else q <= d;
   end

   // storage array, written from the queue head
   always_ff @(posedge SYS_CLK) begin
      if (f_out_valid && f_out_ready) begin
         mem_q[f_out_data[FIFO_W-1 -: ADDR_W]] <= f_out_data[BYTE_W-1:0]; // [RULE1] [RULE10]
      end
   end

   // ============================================================
   // assertions
   localparam int DRAIN_MIN = 1;
   localparam int DRAIN_MAX = 20;

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_B);

   sequence s_quiet;
      !start_ev && !stop_ev;
   endsequence

   sequence s_wr_push;
      f_push;
   endsequence

   sequence s_drained;
      !f_out_valid;
   endsequence

   sequence s_wr_decide;
      q.phase == P_WR && fall_ev && q.cnt == CNT_LAST_DATA ##0 s_quiet;
   endsequence

   a_start_abort: assert property ( // [RULE13]
      start_ev |=> q.phase == P_DEV && q.cnt == CNT_RST && !q.drv)
      else $error("start did not restart the byte engine");

   a_stop_idle: assert property ( // [RULE13]
      (stop_ev && !start_ev) |=> q.phase == P_IDLE && !q.drv)
      else $error("stop did not idle the byte engine");

   a_wp_block: assert property ( // [RULE4]
      f_push |-> !(wp_s && q.addr[ADDR_W-1]))
      else $error("protected byte queued for the array");

   a_wp_nack: assert property ( // [RULE16]
      (s_wr_decide ##0 (wp_s && q.addr[ADDR_W-1])) |=> !q.drv && !q.ack)
      else $error("protected byte was acknowledged");

   a_wp_open: assert property ( // [RULE5]
      (s_wr_decide ##0 (!wp_s && f_in_ready)) |=> q.drv && q.ack)
      else $error("unprotected byte was refused");

   a_addr_hold: assert property ( // [RULE16]
      (q.phase == P_WR && rise_ev && q.cnt == CNT_LAST_DATA && !q.ack ##0 s_quiet) |=> $stable(q.addr))
      else $error("address moved on a refused byte");

   a_addr_step: assert property ( // [RULE15]
      s_wr_push |=> q.addr == addr_inc($past(q.addr)))
      else $error("address did not step after a written byte");

   a_type_gate: assert property ( // [RULE17]
      (q.phase == P_DEV && fall_ev && q.cnt == CNT_LAST_DATA && sa_type(q.sh[6:0]) != DEV_TYPE ##0 s_quiet)
      |=> !q.drv ##1 !q.ack)
      else $error("foreign type code was acknowledged");

   a_word_join: assert property ( // [RULE8]
      (q.phase == P_WORD && rise_ev && q.cnt == CNT_LAST_DATA ##0 s_quiet)
      |=> q.addr == {$past(q.addr[ADDR_W-1 -: PAGE_W]), $past(sh_new)})
      else $error("byte address not page over word");

   a_commit_fast: assert property ( // [RULE9] [RULE10]
      s_wr_push |-> ##[DRAIN_MIN:DRAIN_MAX] s_drained)
      else $error("written byte not committed in time");

   a_read_bit: assert property ( // [RULE2]
      (q.phase == P_RD && fall_ev && q.cnt == CNT_RST ##0 s_quiet) |=> q.drv == !q.tx[BYTE_W-2])
      else $error("read bit scheduled from the wrong position");
endmodule

// [hw/tnvm_pkg.sv]
// ============================================================
// Purpose: shared constants and types of the two-wire memory slave
// Assumes: byte engine on SYS_CLK, bit capture and drive on SCL
// Notes: slave address layout is type[7:4], page[3:1], dir[0]
// ============================================================
// Contract
// [RULE1] store 2,048 bytes of 8 bits, reachable only over the two-wire bus
// [RULE2] when sending, change the data line on the serial clock falling edge
// [RULE3] when receiving, sample the data line on the serial clock rising edge
// [RULE4] with write protect high, refuse writes where the page top bit is one
// [RULE5] with write protect low, accept writes everywhere
// [RULE6] word address byte is 8 bits and picks one of 256 page bytes
// [RULE7] a 3-bit page select picks one of eight 256-byte pages
// [RULE8] byte address is page select above word address, 11 bits total
// [RULE9] commit each received byte right after its transfer, no bus wait
// [RULE10] array writes finish before a new transaction can arrive
// [RULE11] data line is open drain: pull low or release, never drive high
// [RULE12] power-on reset idles the interface; no other power logic
// [RULE13] a start condition abandons any operation and awaits a slave address
// [RULE14] first byte: bits three to one page select, bit zero direction
// [RULE15] address latch steps after each byte before the acknowledge, wraps
// [RULE16] no acknowledge and no address step for protected data bytes
// [RULE17] answer only a matching type code, else ignore until next start
// [RULE18] master makes every clock pulse and holds write protect defined
package tnvm_pkg;
   localparam int MEM_BYTES = 2048;
   localparam int ADDR_W = 11;
   localparam int PAGE_W = 3;
   localparam int WORD_W = 8;
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W = ADDR_W + BYTE_W;
   // value is arbitrary
   localparam logic [3:0] DEV_TYPE_DFLT = 4'h5;
   // slave address byte field positions
   localparam int SA_TYPE_LSB = 4;
   localparam int SA_PAGE_LSB = 1;
   localparam int SA_RW_BIT = 0;
   // bit slot counts within a nine-clock byte frame
   localparam logic [3:0] CNT_RST = 4'h0;
   localparam logic [3:0] CNT_LAST_TX = 4'h6;
   localparam logic [3:0] CNT_LAST_DATA = 4'h7;
   localparam logic [3:0] CNT_ACK = 4'h8;
   localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
   // byte engine phases
   typedef enum logic [2:0] {
      P_IDLE = 3'h0,
      P_DEV = 3'h1,
      P_WORD = 3'h2,
      P_WR = 3'h3,
      P_RD = 3'h4,
      P_DROP = 3'h5
   } tnvm_phase_t;
endpackage

// [hw/tnvm_fifo.sv]
// ============================================================
// Purpose: write queue between byte engine and storage array
// Assumes: one clock, push and pop may share a cycle
// Notes: depth must be a power of two
// ============================================================
module tnvm_fifo #(
   parameter int W = tnvm_pkg::FIFO_W,
   parameter int DEPTH = tnvm_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   import tnvm_pkg::*;
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } tnvm_fptr_t;
   tnvm_fptr_t q, d;
   logic [W-1:0] buf_q [0:DEPTH-1];
   logic push, pop;

   // ============================================================
   // checks
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two of at least two");
   end

   // full when pointers differ only in the wrap bit
   assign in_ready = (q.wr ^ q.rd) != {1'b1, {AW{1'b0}}};
   assign out_valid = q.wr != q.rd;
   assign out_data = buf_q[q.rd[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // pointer update
   always_comb begin
      d = q;
      if (push) d.wr = q.wr + 1'b1;
      if (pop) d.rd = q.rd + 1'b1;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) q <= '0;
      else q <= d;
   end

   // storage, no reset needed
   always_ff @(posedge clk) begin
      if (push) buf_q[q.wr[AW-1:0]] <= in_data;
   end
endmodule

// [hw/tnvm_link.sv]
// ============================================================
// Purpose: bit capture and open-drain drive clocked by the serial clock
// Assumes: drive request is steady around each falling edge
// Notes: a gated request drives only after a sampled acknowledge
// ============================================================
module tnvm_link (
   // serial clock domain
   input wire logic scl,
   input wire logic rst_b,
   input wire logic sda_in,
   // drive request from the byte engine
   input wire logic drv_req,
   input wire logic drv_gate,
   // toward the byte engine and the pin
   output logic bit_q,
   output logic bit_tog_q,
   output logic sda_oe_q
);
   // rising edge: sample the line and flag a new bit
   always_ff @(posedge scl or negedge rst_b) begin
      if (!rst_b) begin
         bit_q <= 1'b1;
         bit_tog_q <= 1'b0;
      end else begin
         bit_q <= sda_in; // [RULE3]
         bit_tog_q <= ~bit_tog_q;
      end
   end

   // falling edge: pull low or release, gated by master acknowledge
   always_ff @(negedge scl or negedge rst_b) begin
      if (!rst_b) sda_oe_q <= 1'b0;
      else sda_oe_q <= drv_req && !(drv_gate && bit_q); // [RULE2] [RULE11]
   end
endmodule

// [testbench/tnvm_master.sv]
// ============================================================
// Purpose: two-wire bus master model for the memory slave bench
// Assumes: 48 ns serial clock, clock stands high between frames
// Notes: data line is only pulled low or released to the pull-up
// ============================================================
module tnvm_master (
   // serial clock made here
   output logic scl,
   // pull on the data line and the resolved line level
   output logic sda_low,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   realtime shift = 1.3;

   // clock parked high and line released until the first frame
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // one bit slot: data set mid low phase, line sampled at the rise
   task automatic bit_slot(input logic v, output logic s);
      #12 sda_low = !v;
      #12 scl = 1'b1;
      s = sda;
      #24 scl = 1'b0;
   endtask

   // start or repeated start; idle starts drift so phase keeps moving
   task automatic start_cond();
      if (scl === 1'b0) begin
         #12 sda_low = 1'b0;
         #12 scl = 1'b1;
      end else begin
         #(shift);
         shift = (shift > 6.0) ? shift - 6.0 : shift + 1.7;
      end
      #24 sda_low = 1'b1;
      #24 scl = 1'b0;
   endtask

   // stop condition, then idle with both lines high
   task automatic stop_cond();
      #12 sda_low = 1'b1;
      #12 scl = 1'b1;
      #24 sda_low = 1'b0;
      #24;
   endtask

   // eight bits msb first, then the acknowledge slot
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_seen);
      for (int i = 7; i >= 0; i--) begin
         bit_slot(tx[i], rx[i]);
      end
      bit_slot(ack_in, ack_seen);
   endtask
endmodule

// [testbench/tnvm_top_tb.sv]
// ============================================================
// Purpose: self-checking bench of the two-wire memory slave
// Assumes: master model makes the serial clock, pull-up on data
// Notes: a shadow array holds every byte that the row writes should store
// ============================================================
module tnvm_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import tnvm_pkg::*;

   typedef struct packed {
      logic [10:0] addr;
      logic [7:0] data;
      logic wp;
      logic ack;
   } tnvm_row_t;

   logic SYS_CLK;
   logic RST_B = 1'b1;
   logic WP = 1'b0;
   logic SCL;
   logic SDA_OUT;
   logic SDA_OE;
   logic sda_low;
   logic sda;
   logic [7:0] rx;
   logic [7:0] rd;
   logic ack;
   logic [7:0] shadow [MEM_BYTES];
   int bad_count = 0;
   int checked = 0;
   realtime t_fall = 0.0;
   // pages 0-7 at one word, then three rows with write protect high
   tnvm_row_t rows [11] = '{
      '{11'h05c, 8'h80, 1'b0, 1'b1}, '{11'h15c, 8'h81, 1'b0, 1'b1},
      '{11'h25c, 8'h82, 1'b0, 1'b1}, '{11'h35c, 8'h83, 1'b0, 1'b1},
      '{11'h45c, 8'h84, 1'b0, 1'b1}, '{11'h55c, 8'h85, 1'b0, 1'b1},
      '{11'h65c, 8'h86, 1'b0, 1'b1}, '{11'h75c, 8'h87, 1'b0, 1'b1},
      '{11'h45c, 8'hee, 1'b1, 1'b0}, '{11'h35c, 8'h33, 1'b1, 1'b1},
      '{11'h75c, 8'h6b, 1'b1, 1'b0}
   };

   // wired-and data line with pull-up
   assign sda = (SDA_OE ? SDA_OUT : 1'b1) & !sda_low;

   tnvm_top dut (
      .SYS_CLK(SYS_CLK),
      .RST_B(RST_B),
      .SCL(SCL),
      .SDA_IN(sda),
      .SDA_OUT(SDA_OUT),
      .SDA_OE(SDA_OE),
      .WP(WP)
   );

   tnvm_master master (
      .scl(SCL),
      .sda_low(sda_low),
      .sda(sda)
   );

   // system clock
   initial begin
      SYS_CLK = 1'b0;
      forever #4 SYS_CLK = !SYS_CLK;
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // slave address byte: type, page, direction
   function automatic logic [7:0] sa(input logic [2:0] pg, input logic rdir);
      return {DEV_TYPE_DFLT, pg, rdir};
   endfunction

   // strap changed just after a clock edge, then given time to settle
   task automatic set_wp(input logic v);
      @(posedge SYS_CLK);
      #1 WP = v;
      repeat (4) @(posedge SYS_CLK);
   endtask

   // address phase and one data byte; caller stops or continues
   task automatic write_at(input logic [10:0] a, input logic [7:0] d, input logic exp_ack);
      master.start_cond();
      master.xfer(sa(a[10:8], 1'b0), 1'b1, rx, ack);
      chk("address ack", 8'h00, {7'h0, ack});
      master.xfer(a[7:0], 1'b1, rx, ack);
      chk("word ack", 8'h00, {7'h0, ack});
      master.xfer(d, 1'b1, rx, ack);
      chk("data ack", {7'h0, !exp_ack}, {7'h0, ack});
   endtask

   // random read: load the latch, repeated start, first byte
   task automatic read_at(input logic [10:0] a, input logic more, output logic [7:0] d);
      master.start_cond();
      master.xfer(sa(a[10:8], 1'b0), 1'b1, rx, ack);
      master.xfer(a[7:0], 1'b1, rx, ack);
      master.start_cond();
      master.xfer(sa(a[10:8], 1'b1), 1'b1, rx, ack);
      chk("read address ack", 8'h00, {7'h0, ack});
      master.xfer(8'hff, !more, d, ack);
   endtask

   // the device may move the data line only at a serial clock fall
   always @(negedge SCL) t_fall = $realtime;
   always @(SDA_OE) begin
      if (RST_B === 1'b1 && $realtime - t_fall > 1.0) begin
         chk("drive moment", 8'h00, 8'h01);
      end
   end
   always @(posedge SCL) begin
      chk("open drain value", 8'h00, {7'h0, SDA_OUT});
   end

   // watchdog: the run needs about 51 us, over five times that is a hang
   initial begin
      #280000;
      bad_count++;
      $display("watchdog expired");
      tally_and_finish();
   end

   initial begin
      // a real falling edge on reset: the serial clock flops see no clock while it is held
      #1 RST_B = 1'b0;
      repeat (20) @(posedge SYS_CLK);
      chk("line released in reset", 8'h00, {7'h0, SDA_OE});
      #1 RST_B = 1'b1;
      repeat (4) @(posedge SYS_CLK);
      // write pass then read pass, so aliasing between pages shows
      foreach (rows[i]) begin
         set_wp(rows[i].wp);
         write_at(rows[i].addr, rows[i].data, rows[i].ack);
         master.stop_cond();
         if (rows[i].ack) shadow[rows[i].addr] = rows[i].data;
      end
      foreach (rows[i]) begin
         read_at(rows[i].addr, 1'b0, rd);
         master.stop_cond();
         chk("row readback", shadow[rows[i].addr], rd);
      end
      $display("test rows done");
      // foreign type code is ignored for the whole frame
      master.start_cond();
      master.xfer({DEV_TYPE_DFLT ^ 4'h1, 3'h0, 1'b0}, 1'b1, rx, ack);
      chk("foreign address ack", 8'h01, {7'h0, ack});
      master.xfer(8'h00, 1'b1, rx, ack);
      chk("foreign byte ack", 8'h01, {7'h0, ack});
      master.stop_cond();
      $display("test foreign type done");
      // refused byte leaves latch alone: current read gets the old byte
      set_wp(1'b1);
      write_at(11'h45c, 8'h5e, 1'b0);
      master.stop_cond();
      master.start_cond();
      master.xfer(sa(3'h4, 1'b1), 1'b1, rx, ack);
      master.xfer(8'hff, 1'b1, rd, ack);
      master.stop_cond();
      chk("latch after refusal", 8'h84, rd);
      $display("test protected latch done");
      // burst across the top address wraps to zero
      set_wp(1'b0);
      write_at(11'h7ff, 8'hd1, 1'b1);
      master.xfer(8'hd2, 1'b1, rx, ack);
      chk("wrap byte ack", 8'h00, {7'h0, ack});
      master.xfer(8'hd3, 1'b1, rx, ack);
      master.stop_cond();
      read_at(11'h000, 1'b1, rd);
      chk("wrapped byte", 8'hd2, rd);
      master.xfer(8'hff, 1'b1, rd, ack);
      master.stop_cond();
      chk("sequential read", 8'hd3, rd);
      read_at(11'h7ff, 1'b0, rd);
      master.stop_cond();
      chk("top byte", 8'hd1, rd);
      $display("test wrap done");
      // start in mid byte abandons the write and keeps the latch
      write_at(11'h020, 8'h77, 1'b1);
      master.stop_cond();
      master.start_cond();
      master.xfer(sa(3'h0, 1'b0), 1'b1, rx, ack);
      master.xfer(8'h20, 1'b1, rx, ack);
      repeat (4) master.bit_slot(1'b0, ack);
      master.start_cond();
      master.xfer(sa(3'h0, 1'b1), 1'b1, rx, ack);
      chk("address after abort", 8'h00, {7'h0, ack});
      master.xfer(8'hff, 1'b1, rd, ack);
      master.stop_cond();
      chk("aborted write", 8'h77, rd);
      $display("test abort done");
      tally_and_finish();
   end
endmodule
